//--- sdt_pkg.sv
// Shared constants and types for the step and direction microstep translator.
`default_nettype none

package sdt_pkg;

	// Phase index geometry: one electrical cycle of sixteenth microsteps.
	localparam int          IDX_W           = 6;
	localparam int          PHASE_POSITIONS = 64;
	localparam int          DAC_W           = 6;
	localparam logic [5:0]  IDX_RST         = 6'h00;

	// Register byte offsets on the Wishbone bus.
	localparam logic [3:0]  REG_CFG         = 4'h0;
	localparam logic [3:0]  REG_STEPCHG     = 4'h4;
	localparam logic [3:0]  REG_STATUS      = 4'h8;

	// Configuration register fields and reset value.
	localparam int          CFG_LO_BIT      = 0;
	localparam int          CFG_HI_BIT      = 1;
	localparam logic [1:0]  CFG_RST         = 2'h0;

	// Step change register field (signed, two's complement).
	localparam int          SC_LSB          = 0;

	// Status register field positions.
	localparam int          STAT_IDX_LSB    = 0;
	localparam int          STAT_RES_LSB    = 8;
	localparam int          STAT_AMAG_LSB   = 16;
	localparam int          STAT_ANEG_BIT   = 22;
	localparam int          STAT_BMAG_LSB   = 24;
	localparam int          STAT_BNEG_BIT   = 30;

	// Permitted index grids per resolution: spacing and offset.
	localparam logic [5:0]  GRID_FULL       = 6'h10;
	localparam logic [5:0]  GRID_HALF       = 6'h08;
	localparam logic [5:0]  GRID_QUARTER    = 6'h04;
	localparam logic [5:0]  GRID_SIXTEENTH  = 6'h01;
	localparam logic [5:0]  FULL_OFS        = 6'h08;

	// Phase current full scale code.
	localparam logic [5:0]  FULL_SCALE      = 6'h3f;

	// Resolution selected by the two effective select bits.
	typedef enum logic [1:0] {
		RES_FULL,
		RES_HALF,
		RES_QUARTER,
		RES_SIXTEENTH
	} sdt_res_t;

endpackage

`default_nettype wire

//--- sdt_step_host.sv
// Motion-control host model that drives the step, direction and resolution pins.
`default_nettype none

module sdt_step_host (
	// Clock shared with the translator.
	input  wire logic clock,
	// Pins toward the translator.
	output var logic  stepIn,
	output var logic  travelSense,
	output var logic  resLo,
	output var logic  resHi
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle levels at time zero; step stays low outside pulses.
	initial begin
		stepIn = 1'b0;
		travelSense = 1'b1;
		resLo = 1'b0; // Pins low leave the register in full control.
		resHi = 1'b0;
	end

	// One step pulse; direction and select settle a cycle before the rise and stay put.
	// Step stays high three cycles, so the translator must ignore a level held past its edge.
	// A short gap models a prompt host, a long one a slow host.
	task automatic pulse(input logic fwd, input logic [1:0] res, input int gap);
		@(posedge clock);
		travelSense <= fwd;
		{resHi, resLo} <= res;
		@(posedge clock);
		stepIn <= 1'b1;
		repeat (3) @(posedge clock);
		stepIn <= 1'b0;
		repeat (gap) @(posedge clock);
	endtask
endmodule

`default_nettype wire

//--- sdt_translator.sv
// Step and direction microstep translator with phase current table and Wishbone registers.
`default_nettype none

module sdt_translator
	import sdt_pkg::*;
#(
	parameter int ADR_W = 4
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             sys_rst,
	// Motion control inputs.
	input  wire logic             stepIn,
	input  wire logic             travelSense,
	input  wire logic             res_sel_lo,
	input  wire logic             res_sel_hi,
	// Wishbone classic slave.
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// Phase index and current converter codes.
	output logic      [5:0]       phaseIdx,
	output logic      [5:0]       dacAMag,
	output logic                  dacANeg,
	output logic      [5:0]       dacBMag,
	output logic                  dacBNeg
);

	// Registers and the next index value.
	logic       stepMeta_q;
	logic       stepSync_q;
	logic       stepLast_q;
	logic [1:0] cfgRes_q;
	logic [5:0] idx_q;
	logic [5:0] idx_d;
	logic       ack_q;
	logic [31:0] rdData_q;
	logic [5:0] aMag_q;
	logic       aNeg_q;
	logic [5:0] bMag_q;
	logic       bNeg_q;

	// Combinational wires.
	logic       stepEdge;
	logic [1:0] effRes;
	sdt_res_t   resMode;
	logic [5:0] gridSize;
	logic [5:0] gridOfs;
	logic [5:0] gridMask;
	logic [5:0] relIdx;
	logic [5:0] fwdBase;
	logic [5:0] revBase;
	logic [5:0] stepTarget;
	logic       busReq;
	logic       busDone;
	logic       wrLane0;
	logic       cfgWrite;
	logic       scWrite;
	logic [5:0] scVal;
	logic [3:0] adrLow;
	logic       adrHigh;
	logic [31:0] rdMux;
	logic [1:0] quad;
	logic [3:0] sub;
	logic [5:0] aMag_d;
	logic       aNeg_d;
	logic [5:0] bMag_d;
	logic       bNeg_d;

	// Quarter sine of the table, entries 0 to 16 of one quadrant.
	function automatic logic [5:0] quarterSine(input logic [4:0] k);
		logic [5:0] v;
		v = 6'h00;
		case (k)
			5'h00: v = 6'h00;
			5'h01: v = 6'h06;
			5'h02: v = 6'h0c;
			5'h03: v = 6'h12;
			5'h04: v = 6'h18;
			5'h05: v = 6'h1e;
			5'h06: v = 6'h23;
			5'h07: v = 6'h28;
			5'h08: v = 6'h2d;
			5'h09: v = 6'h31;
			5'h0a: v = 6'h34;
			5'h0b: v = 6'h38;
			5'h0c: v = 6'h3a;
			5'h0d: v = 6'h3c;
			5'h0e: v = 6'h3e;
			5'h0f: v = 6'h3f;
			default: v = FULL_SCALE;
		endcase
		return v;
	endfunction

	// Step synchroniser; only the second stage and its delayed copy feed the edge detect.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stepMeta_q <= 1'b0;
			stepSync_q <= 1'b0;
			stepLast_q <= 1'b0;
		end else begin
			stepMeta_q <= stepIn;
			stepSync_q <= stepMeta_q;
			stepLast_q <= stepSync_q;
		end
	end

	// One pulse per rising edge, however long the step pulse stays high.
	assign stepEdge = stepSync_q & ~stepLast_q;

	// Effective select bits: a pin held high cannot be overridden by software.
	assign effRes = {res_sel_hi | cfgRes_q[CFG_HI_BIT], res_sel_lo | cfgRes_q[CFG_LO_BIT]};

	// Decode the select into a resolution.
	always_comb begin
		case (effRes)
			2'h0: resMode = RES_FULL;
			2'h1: resMode = RES_HALF;
			2'h2: resMode = RES_QUARTER;
			2'h3: resMode = RES_SIXTEENTH;
			default: resMode = RES_SIXTEENTH;
		endcase
	end

	// Grid of permitted indices; full step is the only grid with an offset.
	assign gridSize = (resMode == RES_FULL)    ? GRID_FULL :
	                  (resMode == RES_HALF)    ? GRID_HALF :
	                  (resMode == RES_QUARTER) ? GRID_QUARTER :
	                                             GRID_SIXTEENTH;
	assign gridOfs  = (resMode == RES_FULL) ? FULL_OFS : 6'h00;
	assign gridMask = ~(gridSize - 6'h01);

	// Nearest permitted index strictly past the present one in the travel direction.
	// All sums are six bits wide, so wrapping past 63 or below 0 comes for free.
	assign relIdx     = idx_q - gridOfs;
	assign fwdBase    = (relIdx & gridMask) + gridSize;
	assign revBase    = ((relIdx + gridSize - 6'h01) & gridMask) - gridSize;
	assign stepTarget = (travelSense ? fwdBase : revBase) + gridOfs;

	// Bus decode; a write lands at the edge that samples the acknowledge.
	assign busReq   = wb_cyc_i & wb_stb_i;
	assign busDone  = busReq & ack_q;
	assign adrLow   = wb_adr_i[3:0];
	assign adrHigh  = (ADR_W > 4) ? |(wb_adr_i >> 4) : 1'b0;
	assign wrLane0  = busDone & wb_we_i & wb_sel_i[0] & ~adrHigh;
	assign cfgWrite = wrLane0 & (adrLow == REG_CFG);
	assign scWrite  = wrLane0 & (adrLow == REG_STEPCHG);
	assign scVal    = wb_dat_i[SC_LSB +: 6];

	// Next index: the step path first, then any step change number on top of it.
	// Both may fall in one cycle; neither is dropped.
	always_comb begin
		idx_d = idx_q;
		if (stepEdge) begin
			idx_d = stepTarget;
		end
		if (scWrite) begin
			idx_d = idx_d + scVal;
		end
	end

	// Index register, reset to the zero angle.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			idx_q <= IDX_RST;
		end else begin
			idx_q <= idx_d;
		end
	end

	// Phase current lookup by quadrant: A follows sine, B follows cosine.
	assign quad = idx_q[5:4];
	assign sub  = idx_q[3:0];
	always_comb begin
		if (quad[0]) begin
			aMag_d = quarterSine(5'h10 - {1'b0, sub});
			bMag_d = quarterSine({1'b0, sub});
		end else begin
			aMag_d = quarterSine({1'b0, sub});
			bMag_d = quarterSine(5'h10 - {1'b0, sub});
		end
		aNeg_d = quad[1] & (aMag_d != 6'h00);
		bNeg_d = (quad[0] ^ quad[1]) & (bMag_d != 6'h00);
	end

	// Converter codes are registered so the outputs never glitch mid-update.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aMag_q <= 6'h00;
			aNeg_q <= 1'b0;
			bMag_q <= FULL_SCALE;
			bNeg_q <= 1'b0;
		end else begin
			aMag_q <= aMag_d;
			aNeg_q <= aNeg_d;
			bMag_q <= bMag_d;
			bNeg_q <= bNeg_d;
		end
	end

	// Configuration register; bits clear at reset so the pins govern alone.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfgRes_q <= CFG_RST;
		end else if (cfgWrite) begin
			cfgRes_q <= {wb_dat_i[CFG_HI_BIT], wb_dat_i[CFG_LO_BIT]};
		end
	end

	// Read multiplexer; unmapped offsets and the write-only step change read zero.
	always_comb begin
		rdMux = 32'h0000_0000;
		if (!adrHigh) begin
			case (adrLow)
				REG_CFG: begin
					rdMux[CFG_HI_BIT] = cfgRes_q[CFG_HI_BIT];
					rdMux[CFG_LO_BIT] = cfgRes_q[CFG_LO_BIT];
				end
				REG_STATUS: begin
					rdMux[STAT_IDX_LSB +: 6]  = idx_q;
					rdMux[STAT_RES_LSB +: 2]  = effRes;
					rdMux[STAT_AMAG_LSB +: 6] = aMag_q;
					rdMux[STAT_ANEG_BIT]      = aNeg_q;
					rdMux[STAT_BMAG_LSB +: 6] = bMag_q;
					rdMux[STAT_BNEG_BIT]      = bNeg_q;
				end
				default: rdMux = 32'h0000_0000;
			endcase
		end
	end

	// Acknowledge one cycle after the request and drop it the cycle after.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ack_q    <= 1'b0;
			rdData_q <= 32'h0000_0000;
		end else begin
			ack_q    <= busReq & ~ack_q;
			rdData_q <= rdMux;
		end
	end

	// Outputs.
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdData_q;
	assign phaseIdx = idx_q;
	assign dacAMag  = aMag_q;
	assign dacANeg  = aNeg_q;
	assign dacBMag  = bMag_q;
	assign dacBNeg  = bNeg_q;

	// Full step lands only on the 45 degree positions.
	a_full_grid: assert property (
		@(posedge clock) disable iff (sys_rst)
		(stepEdge && !scWrite && resMode == RES_FULL) |=> (idx_q[3:0] == 4'h8)
	) else $error("full step left the 45 degree grid");

	// Half step lands only on multiples of eight.
	a_half_grid: assert property (
		@(posedge clock) disable iff (sys_rst)
		(stepEdge && !scWrite && resMode == RES_HALF) |=> (idx_q[2:0] == 3'h0)
	) else $error("half step left the multiple of eight grid");

	// Quarter step lands only on multiples of four.
	a_quarter_grid: assert property (
		@(posedge clock) disable iff (sys_rst)
		(stepEdge && !scWrite && resMode == RES_QUARTER) |=> (idx_q[1:0] == 2'h0)
	) else $error("quarter step left the multiple of four grid");

	// Sixteenth step forward adds exactly one, modulo 64.
	a_sixteenth_fwd: assert property (
		@(posedge clock) disable iff (sys_rst)
		(stepEdge && !scWrite && resMode == RES_SIXTEENTH && travelSense)
		|=> (idx_q == 6'($past(idx_q) + 6'h01))
	) else $error("sixteenth forward step did not add one");

	// Sixteenth step reverse subtracts exactly one, modulo 64.
	a_sixteenth_rev: assert property (
		@(posedge clock) disable iff (sys_rst)
		(stepEdge && !scWrite && resMode == RES_SIXTEENTH && !travelSense)
		|=> (idx_q == 6'($past(idx_q) - 6'h01))
	) else $error("sixteenth reverse step did not subtract one");

	// Half step forward from 59 wraps to 0.
	a_wrap_forward: assert property (
		@(posedge clock) disable iff (sys_rst)
		(stepEdge && !scWrite && resMode == RES_HALF && travelSense && idx_q == 6'h3b)
		|=> (idx_q == 6'h00)
	) else $error("forward search did not wrap past 63");

	// A held step level gives a single update, then the index rests.
	a_single_update: assert property (
		@(posedge clock) disable iff (sys_rst)
		(stepEdge && !scWrite) ##1 (stepSync_q && !scWrite)[*2] |=> $stable(idx_q)
	) else $error("held step level moved the index again");

	// The step change number is added whatever the resolution.
	a_stepchg_add: assert property (
		@(posedge clock) disable iff (sys_rst)
		(scWrite && !stepEdge) |=> (idx_q == 6'($past(idx_q) + $past(scVal)))
	) else $error("step change number not added to the index");

	// Index zero shows phase B at positive full scale and phase A at zero.
	a_zero_angle: assert property (
		@(posedge clock) disable iff (sys_rst)
		(idx_q == 6'h00) |=> (dacBMag == FULL_SCALE && !dacBNeg && dacAMag == 6'h00)
	) else $error("zero angle currents wrong");

	// The acknowledge is one cycle wide.
	a_ack_pulse: assert property (
		@(posedge clock) disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o
	) else $error("acknowledge held for more than one cycle");

endmodule

`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the step and direction microstep translator.
`default_nettype none

module testbench
	import sdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// Clock, reset and Wishbone master signals.
	logic        clock;
	logic        sys_rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [3:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	// Translator outputs, host pins and check counters.
	logic [31:0] datO;
	logic        ack;
	logic [5:0]  phaseIdx;
	logic [5:0]  dacAMag;
	logic [5:0]  dacBMag;
	logic        dacANeg;
	logic        dacBNeg;
	logic        stepIn;
	logic        travelSense;
	logic        resLo;
	logic        resHi;
	int          failures = 0;
	int          samples_checked = 0;

	// Byte lanes stay all on: every writable register sits in lane 0.
	sdt_translator #(.ADR_W(4)) i_dut (
		.clock(clock), .sys_rst(sys_rst), .stepIn(stepIn), .travelSense(travelSense),
		.res_sel_lo(resLo), .res_sel_hi(resHi), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(datO),
		.wb_ack_o(ack), .phaseIdx(phaseIdx), .dacAMag(dacAMag), .dacANeg(dacANeg),
		.dacBMag(dacBMag), .dacBNeg(dacBNeg)
	);

	sdt_step_host i_host (
		.clock(clock), .stepIn(stepIn), .travelSense(travelSense), .resLo(resLo),
		.resHi(resHi)
	);

	// Clock with a 100 ns period.
	initial clock = 1'b0;
	always #50 clock = ~clock;

	// Compare one value and count it.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] e);
		samples_checked++;
		if (seen !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, seen);
		end
	endtask

	// One classic cycle, held until ack is sampled, released right after it.
	task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) chk("wb_ack_o", 32'h0, 32'h1);
	endtask

	task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk("wb_dat_o", rdat, e);
	endtask

	// Sampled at the falling edge, well clear of the updates.
	task automatic idxIs(input logic [5:0] e);
		@(negedge clock);
		chk("phaseIdx", 32'(phaseIdx), 32'(e));
	endtask

	task automatic dacIs(input logic [13:0] e);
		chk("dac", 32'({dacBNeg, dacBMag, dacANeg, dacAMag}), 32'(e));
	endtask

	// State after reset; an unmapped write must not reach the select bits.
	task automatic tReset();
		idxIs(6'h00);
		dacIs({1'b0, 6'h3f, 1'b0, 6'h00});
		rdChk(REG_CFG, 32'h0);
		rdChk(REG_STATUS, 32'h3f000000);
		wb(1'b1, 4'hc, 32'h3);
		rdChk(4'hc, 32'h0);
		rdChk(REG_CFG, 32'h0);
	endtask

	// Pin and register bits combine into sixteenth step; reverse wraps below zero.
	task automatic tSixteenth();
		wb(1'b1, REG_CFG, 32'h2);
		i_host.pulse(1'b1, 2'b01, 5);
		idxIs(6'h01);
		rdChk(REG_STATUS, 32'h3f060301);
		i_host.pulse(1'b0, 2'b01, 1);
		i_host.pulse(1'b0, 2'b01, 5);
		idxIs(6'h3f);
		dacIs({1'b0, 6'h3f, 1'b1, 6'h06});
		wb(1'b1, REG_CFG, 32'h0);
	endtask

	// From 59, each new resolution lands on its next permitted index forward.
	task automatic tResChange();
		logic [5:0] cur;
		logic [5:0] exps [3];
		cur = 6'h3f;
		exps = '{6'h3c, 6'h00, 6'h08};
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, REG_STEPCHG, 32'(6'h3b - cur));
			idxIs(6'h3b);
			i_host.pulse(1'b1, 2'(2 - i), 5);
			idxIs(exps[i]);
			cur = exps[i];
		end
	endtask

	// Full, half and quarter walks on their grids, across the wrap point.
	task automatic tGrid();
		int         e [11];
		logic [1:0] r;
		logic [5:0] x;
		e = '{24, 40, 56, 8, 0, 56, 48, 52, 56, 60, 0};
		for (int i = 0; i < 11; i++) begin
			r = (i < 4) ? 2'b00 : ((i < 7) ? 2'b01 : 2'b10);
			x = 6'(e[i]);
			i_host.pulse(r != 2'b01, r, 5);
			idxIs(x);
			if (i < 4) dacIs({^x[5:4], 6'h2d, x[5], 6'h2d});
		end
	endtask

	// Back-to-back full steps from an off-grid index; parks on a holding position.
	task automatic tPrompt();
		for (int i = 0; i < 4; i++) i_host.pulse(1'b1, 2'b00, 1);
		repeat (4) @(posedge clock);
		idxIs(6'h38);
	endtask

	// Closing report and verdict.
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Reset for six cycles, then the scenarios in turn.
	initial begin
		sys_rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		wdat = 32'h0;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		tReset();
		tSixteenth();
		tResChange();
		tGrid();
		tPrompt();
		end_of_test();
	end

	// Watchdog: the scenarios need well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		end_of_test();
	end
endmodule

`default_nettype wire
